// *** hw/asb_top.sv ***
// Sample buffer sequencer: timer-paced converter rounds stored as 16-bit words in RAM.
// Assumes a converter that answers each start with one done pulse, and RAM that takes a write every cycle.
// Function
// [R1] Each 10-bit result is stored to RAM as one 16-bit word, hardware only.
// [R2] Conversion rounds are triggered by one selectable timer, numbers zero to four.
// [R3] Software configures and starts the chosen timer in repeat mode beforehand.
// [R4] Every trigger converts each selected source once, writing each result.
// [R5] Order in a round: external inputs ascending, then temperature, then supply.
// [R6] Buffer length is 1 to 2047 samples; software keeps it in range.
// [R7] With wrap enabled, writing continues at the first location after the last.
// [R8] With wrap disabled, conversions stop once the buffer is filled.
// [R9] Half-full, full and overflow events are individually selectable interrupt conditions.
// [R10] Software enables at least one interrupt condition when starting.
// [R11] Start reports success or failure; invalid configuration fails and starts nothing.
// [R12] Input range selects full scale of reference or twice reference.
// [R13] Stop command ends sampling at any time, the only end with wrap.
// [R14] Software reads the next write position as a sample count.
// [R15] When full, position reads 2047 without wrap and 0 with wrap.
// [R16] Converter disable halts continuous or accumulating conversions.
// [R17] A result occupies the low 10 bits of its 16-bit word.
// [R18] Half-full fires when position reaches half the length; full at last write.
// [R19] Overflow fires when a sample arrives while full without wrap; it is dropped.
// [R20] The six upper bits of every stored word are zero.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "asb_params.svh"

module asb_top
  import asb_pkg::*;
(
  input wire logic REF_CLK, // 10 MHz clock
  input wire logic RST, // Synchronous reset, high
  input wire logic CE, // Clock enable, freezes all state when low
  input wire logic [4:0] TMR_TICK, // Timer trigger pulses, one per timer
  input wire logic ADC_DONE, // Converter result valid pulse
  input wire logic [9:0] ADC_RESULT, // Converter result
  output logic ADC_START, // Start one conversion
  output logic [2:0] ADC_CH, // Source being converted
  output logic ADC_RANGE, // Input range select
  output logic ADC_HALT, // Converter disable pulse
  output logic RAM_WE, // RAM write strobe
  output logic [15:0] RAM_ADDR, // RAM byte address
  output logic [15:0] RAM_WDATA, // RAM write word
  output logic EVT_HALF, // Half-full event, when selected
  output logic EVT_FULL, // Full event, when selected
  output logic EVT_OVF, // Overflow event, when selected
  input wire logic [7:0] AWADDR, // AXI write address
  input wire logic AWVALID, // AXI write address valid
  output logic AWREADY, // AXI write address ready
  input wire logic [31:0] WDATA, // AXI write data
  input wire logic [3:0] WSTRB, // AXI write strobes
  input wire logic WVALID, // AXI write data valid
  output logic WREADY, // AXI write data ready
  output logic [1:0] BRESP, // AXI write response
  output logic BVALID, // AXI write response valid
  input wire logic BREADY, // AXI write response ready
  input wire logic [7:0] ARADDR, // AXI read address
  input wire logic ARVALID, // AXI read address valid
  output logic ARREADY, // AXI read address ready
  output logic [31:0] RDATA, // AXI read data
  output logic [1:0] RRESP, // AXI read response
  output logic RVALID, // AXI read valid
  input wire logic RREADY // AXI read ready
);

  // ==========================================================
  // Helpers
  function automatic logic [2:0] lowest(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  asb_regs_t s_q, s_d;
  logic start_w, stop_w, dis_w, cfg_ok, last, trig;
  logic [7:0] rem;
  logic [10:0] pos_n;
  logic [2:0] ev;
  logic [15:0] ctrl_w;

  // Tied to configuration so a start can be judged before anything moves
  assign cfg_ok = (s_q.len != 16'h0000) && (s_q.len <= `ASB_LEN_MAX) // R6 R11
    && (s_q.cfg[`ASB_CFG_TSEL_LO +: 3] <= `ASB_TSEL_MAX)
    && (s_q.cfg[`ASB_CFG_MASK_LO +: 8] != 8'h00) && (s_q.cfg[`ASB_CFG_IRQ_LO +: 3] != 3'h0); // R10
  // A selector rewritten past the last timer while running must not index beyond the tick bus
  assign trig = (s_q.cfg[`ASB_CFG_TSEL_LO +: 3] <= `ASB_TSEL_MAX)
    ? TMR_TICK[s_q.cfg[`ASB_CFG_TSEL_LO +: 3]] : 1'b0; // R2
  assign last = ({5'h00, s_q.pos} == (s_q.len - 16'h0001));
  assign rem = s_q.round & ~(8'h01 << s_q.ch);
  assign pos_n = s_q.pos + 11'h001;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.adc_start = 1'b0;
    s_d.adc_halt = 1'b0;
    s_d.ram_we = 1'b0;
    s_d.evt = 3'h0;
    ev = 3'h0;
    ctrl_w = 16'h0000;
    start_w = 1'b0;
    stop_w = 1'b0;
    dis_w = 1'b0;

    // Write channel: address and data held until both are in
    if (s_q.awready && AWVALID) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = AWADDR;
    end
    if (s_q.wready && WVALID) begin
      s_d.w_v = 1'b1;
      s_d.w_d = WDATA;
      s_d.w_s = WSTRB;
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_v && s_q.w_v && !s_q.bvalid) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `ASB_RESP_OKAY;
      case (s_q.aw_a)
        `ASB_OFF_CTRL: begin
          ctrl_w = wmerge(16'h0000, s_q.w_d, s_q.w_s);
          start_w = ctrl_w[`ASB_CTRL_START];
          stop_w = ctrl_w[`ASB_CTRL_STOP];
          dis_w = ctrl_w[`ASB_CTRL_CONV_DIS];
        end
        `ASB_OFF_CFG: s_d.cfg = wmerge(s_q.cfg, s_q.w_d, s_q.w_s);
        `ASB_OFF_LEN: s_d.len = wmerge(s_q.len, s_q.w_d, s_q.w_s);
        `ASB_OFF_BASE: s_d.base = wmerge(s_q.base, s_q.w_d, s_q.w_s);
        `ASB_OFF_STAT: begin
          if (s_q.w_s[0]) begin
            s_d.sticky = s_q.sticky & ~s_q.w_d[2:0];
          end
        end
        `ASB_OFF_POS: s_d.bresp = `ASB_RESP_OKAY;
        default: s_d.bresp = `ASB_RESP_SLVERR;
      endcase
    end

    // Read channel
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && ARVALID) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `ASB_RESP_OKAY;
      case (ARADDR)
        `ASB_OFF_CTRL: s_d.rdata = {29'h0, s_q.fail, s_q.ok, s_q.st != ASB_IDLE};
        `ASB_OFF_CFG: s_d.rdata = {16'h0, s_q.cfg};
        `ASB_OFF_LEN: s_d.rdata = {16'h0, s_q.len};
        `ASB_OFF_BASE: s_d.rdata = {16'h0, s_q.base};
        `ASB_OFF_STAT: s_d.rdata = {29'h0, s_q.sticky};
        `ASB_OFF_POS: s_d.rdata = {21'h0, s_q.pos}; // R14
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = `ASB_RESP_SLVERR;
        end
      endcase
    end

    // ==========================================================
    // Commands
    if (dis_w) begin
      s_d.adc_halt = 1'b1; // R16
    end
    if (start_w) begin
      if (s_q.st == ASB_IDLE && cfg_ok) begin
        s_d.st = ASB_WAIT;
        s_d.pos = 11'h000;
        s_d.ok = 1'b1;
        s_d.fail = 1'b0;
      end else begin
        s_d.ok = 1'b0; // R11
        s_d.fail = 1'b1; // R11
      end
    end

    // ==========================================================
    // Sequencer
    case (s_q.st)
      ASB_IDLE: begin
        s_d.round = 8'h00;
      end
      ASB_WAIT: begin
        // Triggers arriving mid-round are dropped; the timer must leave room for a whole round
        if (trig) begin
          s_d.round = s_q.cfg[`ASB_CFG_MASK_LO +: 8]; // R4
          s_d.ch = lowest(s_q.cfg[`ASB_CFG_MASK_LO +: 8]); // R5
          s_d.adc_start = 1'b1;
          s_d.st = ASB_CONV;
        end
      end
      ASB_CONV: begin
        if (ADC_DONE) begin
          s_d.ram_we = 1'b1; // R1
          s_d.ram_addr = s_q.base + {4'h0, s_q.pos, 1'b0};
          s_d.ram_wdata = {6'h00, ADC_RESULT}; // R17 R20
          s_d.round = rem;
          if (last) begin
            ev[`ASB_STAT_FULL] = 1'b1; // R18
            if (s_q.cfg[`ASB_CFG_WRAP]) begin
              s_d.pos = 11'h000; // R7 R15
            end else begin
              s_d.pos = `ASB_POS_FULL; // R15
              s_d.st = ASB_IDLE; // R8
              ev[`ASB_STAT_OVF] = (rem != 8'h00); // R19
            end
          end else begin
            s_d.pos = pos_n;
            ev[`ASB_STAT_HALF] = ({5'h00, pos_n} == (s_q.len >> 1)); // R18
          end
          if (s_d.st == ASB_CONV) begin
            if (rem != 8'h00) begin
              s_d.ch = lowest(rem); // R4 R5
              s_d.adc_start = 1'b1;
            end else begin
              s_d.st = ASB_WAIT;
            end
          end
        end
      end
      default: s_d.st = ASB_IDLE;
    endcase
    if (stop_w) begin
      s_d.st = ASB_IDLE; // R13
    end

    // Set wins over a clear in the same cycle
    s_d.sticky = s_d.sticky | ev;
    s_d.evt = ev & s_q.cfg[`ASB_CFG_IRQ_LO +: 3]; // R9
    s_d.awready = !s_d.aw_v && !s_d.bvalid;
    s_d.wready = !s_d.w_v && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  // ==========================================================
  // State register
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.st <= ASB_IDLE;
      s_q.cfg <= `ASB_CFG_RST;
      s_q.len <= `ASB_LEN_RST;
      s_q.base <= `ASB_BASE_RST;
      s_q.bresp <= `ASB_RESP_OKAY;
      s_q.rresp <= `ASB_RESP_OKAY;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign ADC_START = s_q.adc_start;
  assign ADC_CH = s_q.ch;
  assign ADC_RANGE = s_q.cfg[`ASB_CFG_RANGE]; // R12
  assign ADC_HALT = s_q.adc_halt;
  assign RAM_WE = s_q.ram_we;
  assign RAM_ADDR = s_q.ram_addr;
  assign RAM_WDATA = s_q.ram_wdata;
  assign EVT_HALF = s_q.evt[`ASB_STAT_HALF];
  assign EVT_FULL = s_q.evt[`ASB_STAT_FULL];
  assign EVT_OVF = s_q.evt[`ASB_STAT_OVF];
  assign AWREADY = s_q.awready;
  assign WREADY = s_q.wready;
  assign BVALID = s_q.bvalid;
  assign BRESP = s_q.bresp;
  assign ARREADY = s_q.arready;
  assign RVALID = s_q.rvalid;
  assign RDATA = s_q.rdata;
  assign RRESP = s_q.rresp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_start_refused: assert property (CE && start_w && !cfg_ok && !stop_w |=> s_q.fail && !s_q.ok) // R11
    else $error("bad start not refused");
  a_word_upper_zero: assert property (RAM_WE |-> RAM_WDATA[15:10] == 6'h00) // R20
    else $error("stored word upper bits not zero");
  a_wrap_to_start: assert property (CE && s_q.st == ASB_CONV && ADC_DONE && last && s_q.cfg[`ASB_CFG_WRAP] // R7
    |=> s_q.pos == 11'h000 && RAM_WE)
    else $error("wrap did not restart position");
  a_full_stops: assert property (CE && s_q.st == ASB_CONV && ADC_DONE && last && !s_q.cfg[`ASB_CFG_WRAP] // R8
    |=> s_q.pos == `ASB_POS_FULL && s_q.st == ASB_IDLE)
    else $error("full buffer did not stop");
  a_stop_idle: assert property (CE && stop_w |=> s_q.st == ASB_IDLE) // R13
    else $error("stop did not end sampling");
  a_trig_starts: assert property (CE && s_q.st == ASB_WAIT && trig && !stop_w // R2
    |=> ADC_START && s_q.st == ASB_CONV)
    else $error("trigger did not start a round");
  a_order_lowest: assert property (ADC_START |-> (s_q.round & ((8'h01 << ADC_CH) - 8'h01)) == 8'h00) // R5
    else $error("source converted out of order");
  a_halt_pulse: assert property (CE && dis_w |=> ADC_HALT ##1 (!ADC_HALT || !CE)) // R16
    else $error("converter disable not pulsed");
  a_half_event: assert property (CE && s_q.st == ASB_CONV && ADC_DONE && !last // R18
    && {5'h00, pos_n} == (s_q.len >> 1) |=> s_q.sticky[`ASB_STAT_HALF])
    else $error("half-full event missed");

  // ==========================================================
  // Event and sequencing checks
  a_bad_start_idle: assert property (CE && start_w && !cfg_ok && s_q.st == ASB_IDLE // R11
    |=> s_q.st == ASB_IDLE)
    else $error("refused start left idle");
  a_idle_no_conv: assert property (CE && s_q.st == ASB_IDLE // R8
    |=> !ADC_START)
    else $error("conversion started while idle");
  a_full_event: assert property (CE && s_q.st == ASB_CONV && ADC_DONE && last // R18
    |=> s_q.sticky[`ASB_STAT_FULL])
    else $error("full event missed");
  a_ovf_event: assert property (CE && s_q.st == ASB_CONV && ADC_DONE && last && !s_q.cfg[`ASB_CFG_WRAP] // R19
    && rem != 8'h00 |=> s_q.sticky[`ASB_STAT_OVF])
    else $error("overflow event missed");
  a_result_low: assert property (CE && s_q.st == ASB_CONV && ADC_DONE // R17
    |=> RAM_WE && RAM_WDATA[9:0] == $past(ADC_RESULT))
    else $error("result not in low bits of word");
  a_event_masked: assert property (CE && !s_q.cfg[`ASB_CFG_IRQ_LO + `ASB_STAT_FULL] // R9
    |=> !EVT_FULL)
    else $error("unselected full event raised");
  a_round_mask: assert property (CE && s_q.st == ASB_WAIT && trig && !stop_w // R4
    |=> s_q.round == $past(s_q.cfg[`ASB_CFG_MASK_LO +: 8]))
    else $error("round did not take source mask");

endmodule

// *** common/asb_params.svh ***
// Register map, field positions, reset values and limits of the sample buffer sequencer.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
`ifndef ASB_PARAMS_SVH
`define ASB_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define ASB_OFF_CTRL 8'h00
`define ASB_OFF_CFG 8'h04
`define ASB_OFF_LEN 8'h08
`define ASB_OFF_BASE 8'h0C
`define ASB_OFF_STAT 8'h10
`define ASB_OFF_POS 8'h14

// ==========================================================
// Field positions
`define ASB_CTRL_START 0
`define ASB_CTRL_STOP 1
`define ASB_CTRL_CONV_DIS 2
`define ASB_CFG_RANGE 0
`define ASB_CFG_WRAP 1
`define ASB_CFG_TSEL_LO 2
`define ASB_CFG_IRQ_LO 5
`define ASB_CFG_MASK_LO 8
`define ASB_STAT_HALF 0
`define ASB_STAT_FULL 1
`define ASB_STAT_OVF 2

// ==========================================================
// Reset values and limits
`define ASB_CFG_RST 16'h0000
`define ASB_LEN_RST 16'h0001
`define ASB_BASE_RST 16'h0000
`define ASB_LEN_MAX 16'h07FF
`define ASB_POS_FULL 11'h7FF
`define ASB_TSEL_MAX 3'h4
`define ASB_RESP_OKAY 2'h0
`define ASB_RESP_SLVERR 2'h2

`endif

// *** common/asb_pkg.sv ***
// Types shared by the sample buffer sequencer.
// Assumes nothing beyond the parameter header.
package asb_pkg;

  typedef enum logic [2:0] {
    ASB_IDLE = 3'b001,
    ASB_WAIT = 3'b010,
    ASB_CONV = 3'b100
  } asb_state_t;

  typedef struct packed {
    asb_state_t st;
    logic [15:0] cfg;
    logic [15:0] len;
    logic [15:0] base;
    logic [10:0] pos;
    logic [2:0] sticky;
    logic ok;
    logic fail;
    logic [7:0] round;
    logic [2:0] ch;
    logic adc_start;
    logic adc_halt;
    logic ram_we;
    logic [15:0] ram_addr;
    logic [15:0] ram_wdata;
    logic [2:0] evt;
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } asb_regs_t;

endpackage

// *** tb/asb_ram_model.sv ***
// Far side of the sequencer: a converter that answers each start and a RAM that logs every word written.
// Assumes one clock shared with the design and a synchronous high reset.
`timescale 1ns/10ps

module asb_ram_model (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic adc_start, // Start one conversion
  input wire logic [2:0] adc_ch, // Source to convert
  output logic adc_done, // Result valid pulse
  output logic [9:0] adc_result, // Result, source number in top bits
  input wire logic ram_we, // Write strobe
  input wire logic [15:0] ram_addr, // Byte address
  input wire logic [15:0] ram_wdata, // Word written
  output int wr_cnt, // Words written since reset
  output int st_cnt // Conversions started since reset
);
  logic [15:0] mem [0:127];
  int wait_n;
  logic slow;

  // ==========================================================
  // Converter, alternately prompt and slow
  always @(posedge clk) begin
    adc_done <= 1'b0;
    if (rst) begin
      wait_n <= 0;
      adc_result <= 10'h000;
      wr_cnt <= 0;
      st_cnt <= 0;
      slow <= 1'b0;
    end else begin
      // Result is only held with the done pulse, so it is scrambled afterwards
      if (adc_done) adc_result <= ~adc_result;
      if (adc_start) begin
        wait_n <= slow ? 4 : 1;
        slow <= ~slow;
        st_cnt <= st_cnt + 1;
      end else if (wait_n == 1) begin
        adc_done <= 1'b1;
        adc_result <= {adc_ch, 7'h5A};
        wait_n <= 0;
      end else if (wait_n > 1) begin
        wait_n <= wait_n - 1;
      end
      if (ram_we) begin
        mem[ram_addr[7:1]] <= ram_wdata;
        wr_cnt <= wr_cnt + 1;
      end
    end
  end
endmodule

// *** tb/asb_top_tb.sv ***
// Self-checking bench of the sample buffer sequencer over its AXI4-Lite port.
// Assumes the converter and RAM model beside it; CE is dropped once to check the freeze.
`timescale 1ns/10ps
`include "asb_params.svh"

module adc_sample_buffer_dma_tb;
  logic REF_CLK, RST, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY, ADC_DONE;
  logic ADC_START, ADC_RANGE, ADC_HALT, RAM_WE, EVT_HALF, EVT_FULL, EVT_OVF;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [4:0] TMR_TICK;
  logic [9:0] ADC_RESULT;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0] WSTRB;
  logic [2:0] ADC_CH;
  logic [15:0] RAM_ADDR, RAM_WDATA, last_addr;
  logic [1:0] BRESP, RRESP, rsp;
  int fail_count = 0, comparisons = 0, wr_cnt, st_cnt, w0, s0;
  int n_half = 0, n_full = 0, n_ovf = 0, n_halt = 0;

  asb_top u_dut (.REF_CLK(REF_CLK), .RST(RST), .CE(CE), .TMR_TICK(TMR_TICK), .ADC_DONE(ADC_DONE),
    .ADC_RESULT(ADC_RESULT), .ADC_START(ADC_START), .ADC_CH(ADC_CH), .ADC_RANGE(ADC_RANGE), .ADC_HALT(ADC_HALT),
    .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA), .EVT_HALF(EVT_HALF), .EVT_FULL(EVT_FULL),
    .EVT_OVF(EVT_OVF), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

  asb_ram_model u_mem (.clk(REF_CLK), .rst(RST), .adc_start(ADC_START), .adc_ch(ADC_CH), .adc_done(ADC_DONE),
    .adc_result(ADC_RESULT), .ram_we(RAM_WE), .ram_addr(RAM_ADDR), .ram_wdata(RAM_WDATA), .wr_cnt(wr_cnt),
    .st_cnt(st_cnt));

  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end

  always @(posedge REF_CLK) begin
    if (EVT_HALF === 1'b1) n_half++;
    if (EVT_FULL === 1'b1) n_full++;
    if (EVT_OVF === 1'b1) n_ovf++;
    if (ADC_HALT === 1'b1) n_halt++;
    if (RAM_WE === 1'b1) last_addr <= RAM_ADDR;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic hang(input string what);
    fail_count++;
    $display("ERROR %s expected answer seen timeout", what);
    complete_run();
  endtask

  // Both channels offered together, each dropped once its own ready is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
      if (BVALID === 1'b1) break;
    end
    if (n == 50) hang("write response");
    r = BRESP;
    BREADY <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
      if (RVALID === 1'b1) break;
    end
    if (n == 50) hang("read data");
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic tick(input int t);
    TMR_TICK <= 5'h01 << t;
    @(posedge REF_CLK);
    TMR_TICK <= 5'h00;
    @(posedge REF_CLK);
  endtask

  // Settle time after the last word lets the registered event pulses land
  task automatic wait_wr(input int n);
    int i;
    for (i = 0; i < 300 && wr_cnt < n; i++) @(posedge REF_CLK);
    if (wr_cnt < n) hang("ram writes");
    repeat (20) @(posedge REF_CLK);
  endtask

  task automatic start(input logic [15:0] cfg, input logic [15:0] len, input logic [2:0] exp);
    axi_wr(`ASB_OFF_CFG, {16'h0000, cfg}, rsp);
    axi_wr(`ASB_OFF_LEN, {16'h0000, len}, rsp);
    axi_wr(`ASB_OFF_BASE, 32'h00000100, rsp);
    axi_wr(`ASB_OFF_CTRL, 32'h00000001, rsp);
    axi_rd(`ASB_OFF_CTRL, rd, rsp);
    chk("start status", {29'h0, exp}, rd);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    axi_rd(`ASB_OFF_LEN, rd, rsp);
    chk("length reset", 32'h00000001, rd);
    axi_wr(`ASB_OFF_POS, 32'h00000005, rsp);
    chk("position write resp", {30'h0, `ASB_RESP_OKAY}, {30'h0, rsp});
    axi_rd(`ASB_OFF_POS, rd, rsp);
    chk("position reset", 32'h00000000, rd);
    axi_rd(8'h18, rd, rsp);
    chk("unmapped resp", {30'h0, `ASB_RESP_SLVERR}, {30'h0, rsp});
    axi_wr(8'h18, 32'h00000001, rsp);
    chk("unmapped write resp", {30'h0, `ASB_RESP_SLVERR}, {30'h0, rsp});
    $display("test reset done");
  endtask

  task automatic t_invalid;
    s0 = st_cnt;
    start(16'h00E8, 16'h0004, 3'h4);
    start(16'hC2E8, 16'h0000, 3'h4);
    start(16'hC2E8, 16'h0800, 3'h4);
    start(16'hC208, 16'h0004, 3'h4);
    start(16'hC2F4, 16'h0004, 3'h4);
    tick(2);
    repeat (10) @(posedge REF_CLK);
    chk("starts after refusal", s0, st_cnt);
    $display("test invalid done");
  endtask

  task automatic t_linear;
    w0 = wr_cnt;
    s0 = st_cnt;
    n_half = 0;
    n_full = 0;
    n_ovf = 0;
    start(16'hC2E9, 16'h0004, 3'h3);
    chk("range", 32'h1, {31'h0, ADC_RANGE});
    tick(0);
    repeat (10) @(posedge REF_CLK);
    chk("other timer", s0, st_cnt);
    tick(2);
    wait_wr(w0 + 3);
    chk("word 0", 32'h000000DA, {16'h0, u_mem.mem[0]});
    chk("word 1", 32'h0000035A, {16'h0, u_mem.mem[1]});
    chk("word 2", 32'h000003DA, {16'h0, u_mem.mem[2]});
    axi_rd(`ASB_OFF_POS, rd, rsp);
    chk("position", 32'h00000003, rd);
    chk("half events", 32'h1, n_half);
    tick(2);
    wait_wr(w0 + 4);
    chk("word 3", 32'h000000DA, {16'h0, u_mem.mem[3]});
    axi_rd(`ASB_OFF_POS, rd, rsp);
    chk("full position", {21'h0, `ASB_POS_FULL}, rd);
    chk("full events", 32'h1, n_full);
    chk("overflow events", 32'h1, n_ovf);
    axi_rd(`ASB_OFF_STAT, rd, rsp);
    chk("status", 32'h00000007, rd);
    tick(2);
    repeat (20) @(posedge REF_CLK);
    chk("writes after full", w0 + 4, wr_cnt);
    $display("test linear done");
  endtask

  task automatic t_wrap;
    axi_wr(`ASB_OFF_STAT, 32'h00000007, rsp);
    w0 = wr_cnt;
    n_half = 0;
    n_full = 0;
    n_halt = 0;
    start(16'h0142, 16'h0002, 3'h3);
    tick(0);
    wait_wr(w0 + 1);
    tick(0);
    wait_wr(w0 + 2);
    axi_rd(`ASB_OFF_POS, rd, rsp);
    chk("wrap full position", 32'h00000000, rd);
    chk("full events", 32'h1, n_full);
    chk("half unselected", 32'h0, n_half);
    tick(0);
    wait_wr(w0 + 3);
    chk("wrapped address", 32'h00000100, {16'h0, last_addr});
    // A frozen clock enable must swallow a trigger without converting
    CE <= 1'b0;
    tick(0);
    repeat (4) @(posedge REF_CLK);
    chk("writes while frozen", w0 + 3, wr_cnt);
    CE <= 1'b1;
    axi_wr(`ASB_OFF_CTRL, 32'h00000002, rsp);
    tick(0);
    repeat (20) @(posedge REF_CLK);
    chk("writes after stop", w0 + 3, wr_cnt);
    axi_wr(`ASB_OFF_CTRL, 32'h00000004, rsp);
    repeat (4) @(posedge REF_CLK);
    chk("disable pulses", 32'h1, n_halt);
    $display("test wrap done");
  endtask

  initial begin
    RST = 1'b1;
    CE = 1'b1;
    TMR_TICK = 5'h00;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h00000000;
    WSTRB = 4'h0;
    repeat (4) @(posedge REF_CLK);
    RST <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    t_reset();
    t_invalid();
    t_linear();
    t_wrap();
    complete_run();
  end
endmodule
